//--- hw/cbl_pkg.sv
// Purpose: shared constants and types for the channel B io config and driver limit bank
// Assumes: 125 MHz system clock, 32-bit classic Wishbone register port
// Notes: register byte address is four times the register index
package cbl_pkg;

  // clock rate used to turn times into cycle counts
  localparam int CLK_MHZ = 125;

  // register indices; byte address = index * 4
  localparam logic [5:0] IDX_CHAN_B_CFG = 6'h1b;
  localparam logic [5:0] IDX_DRV_LIMIT = 6'h1c;
  localparam logic [5:0] IDX_PIN_CTRL = 6'h20;
  localparam logic [5:0] IDX_FAULT_STAT = 6'h21;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h22;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h23;
  localparam int ADR_W = 8;
  localparam int IDX_LSB = 2;

  // channel B input/status/config field positions
  localparam int B_AUX_LVL = 7;
  localparam int B_LINE_LVL = 6;
  localparam int B_TX_EN = 5;
  localparam int B_TX_DAT = 4;
  localparam int B_FILT = 3;
  localparam int B_THRESH = 2;
  localparam int B_SRC = 1;
  localparam int B_SINK = 0;
  localparam int B_WR_MSB = 5;

  // pin control register field
  localparam int PC_SOFT = 0;

  // reset values
  localparam logic [5:0] CFG_B_RST = 6'h00;
  localparam logic [7:0] LIMIT_RST = 8'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // line driver limit register layout, msb first
  typedef struct packed {
    logic [1:0] limit_sel;
    logic limit_off;
    logic [1:0] blank_sel;
    logic [1:0] retry_sel;
    logic retry_on;
  } cbl_limit_t;

  // current limit codes
  localparam logic [1:0] LIM_100MA = 2'h0;
  localparam logic [1:0] LIM_200MA = 2'h1;
  localparam logic [1:0] LIM_300MA = 2'h2;
  localparam logic [1:0] LIM_500MA = 2'h3;

  // times, as printed, and the derived cycle counts (least times, rounded up)
  localparam int T_FILT_NS = 1300;
  localparam int FILT_CYC = (T_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int T_BLANK0_US = 128;
  localparam int T_BLANK1_US = 500;
  localparam int T_BLANK2_US = 1000;
  localparam int T_BLANK3_US = 5000;
  localparam int T_RETRY0_US = 50000;
  localparam int T_RETRY1_US = 100000;
  localparam int T_RETRY2_US = 200000;
  localparam int T_RETRY3_US = 500000;
  localparam int BLANK0_CYC = T_BLANK0_US * CLK_MHZ;
  localparam int BLANK1_CYC = T_BLANK1_US * CLK_MHZ;
  localparam int BLANK2_CYC = T_BLANK2_US * CLK_MHZ;
  localparam int BLANK3_CYC = T_BLANK3_US * CLK_MHZ;
  localparam int RETRY0_CYC = T_RETRY0_US * CLK_MHZ;
  localparam int RETRY1_CYC = T_RETRY1_US * CLK_MHZ;
  localparam int RETRY2_CYC = T_RETRY2_US * CLK_MHZ;
  localparam int RETRY3_CYC = T_RETRY3_US * CLK_MHZ;
  localparam int CNT_W = 26;
  localparam int FCNT_W = 8;

  // driver fault sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_NORMAL = 5'b00001,
    ST_BLANK = 5'b00010,
    ST_OFF = 5'b00100,
    ST_RECHECK = 5'b01000,
    ST_LATCH = 5'b10000
  } cbl_flt_st_t;

  // wishbone request carrier
  typedef struct packed {
    logic [ADR_W-1:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
  } cbl_wb_req_t;

endpackage : cbl_pkg

//--- hw/cbl_io_limit.sv
// Purpose: channel B io config/status bank and shared line driver limit with fault sequencer
// Assumes: pins arrive asynchronous; analog receivers and drivers sit outside
// Notes: one wishbone slave, one clock, synchronous active-high reset
// Function
// - bit 7 reads aux input B level.
// - bit 6 reads line B level.
// - under soft pin control bit 5 replaces the tx enable pin.
// - under soft pin control bit 4 replaces the tx data pin.
// - soft pin control bit ignores external tx pins, uses register bits.
// - bit 3 enables a 1.3us glitch filter on aux input B.
// - bit 2 selects type 2/3 threshold, else type 1.
// - bit 1 turns on aux input B current source.
// - bit 0 turns on aux input B current sink.
// - limit select picks 100/200/300/500 mA when limiting is on.
// - limit-off bit disables driver current limiting on both drivers.
// - blanking select sets overcurrent time before fault: 128us to 5ms.
// - retry select sets off-time after fault: 50ms to 500ms.
// - with autoretry, faulted driver goes off for retry time, then back on; else latched off until a limit write, or for line B until its tx enable drops.
// - with autoretry, recheck after blanking; persisting fault re-disables driver.
// - with autoretry, fault gone at recheck clears fault status, driver returns to normal.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cbl_io_limit
  import cbl_pkg::*;
#(
  parameter int BLANK0 = BLANK0_CYC,
  parameter int BLANK1 = BLANK1_CYC,
  parameter int BLANK2 = BLANK2_CYC,
  parameter int BLANK3 = BLANK3_CYC,
  parameter int RETRY0 = RETRY0_CYC,
  parameter int RETRY1 = RETRY1_CYC,
  parameter int RETRY2 = RETRY2_CYC,
  parameter int RETRY3 = RETRY3_CYC,
  parameter int FILT = FILT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // pins
  input wire logic aux_input_b_i,
  input wire logic line_b_i,
  input wire logic tx_enable_pin_b_i,
  input wire logic tx_data_pin_b_i,
  input wire logic [1:0] drv_overcurrent_i,
  // line B driver control
  output logic line_b_tx_en_o,
  output logic line_b_tx_data_o,
  // aux input B front end
  output logic aux_in_b_filter_on_o,
  output logic aux_in_b_threshold_type_o,
  output logic aux_in_b_source_on_o,
  output logic aux_in_b_sink_on_o,
  // shared driver limit, index 0 is line A, 1 is line B
  output logic [1:0] driver_limit_sel_o,
  output logic driver_limit_off_o,
  output logic [1:0] drv_allow_o,
  output logic [1:0] drv_fault_o,
  output logic irq_o
);

  // elaboration check: select 2 and 3 counts and the filter must fit the counters; blank and retry at least one cycle, filter at least two
  localparam longint CNT_MAX = (64'h1 << CNT_W) - 1;
  localparam longint FCNT_MAX = (64'h1 << FCNT_W) - 1;
  if (BLANK0 < 1 || BLANK1 < 1 || BLANK2 < 1 || BLANK3 < 1 ||
      RETRY0 < 1 || RETRY1 < 1 || RETRY2 < 1 || RETRY3 < 1 ||
      longint'(BLANK3) > CNT_MAX || longint'(RETRY3) > CNT_MAX ||
      longint'(BLANK2) > CNT_MAX || longint'(RETRY2) > CNT_MAX ||
      FILT < 2 || longint'(FILT) > FCNT_MAX) begin : g_bad_param
    $error("cbl_io_limit: timing parameter out of range");
  end

  // blanking count for a select code, minus one for a down-counter
  function automatic logic [CNT_W-1:0] blank_load(input logic [1:0] sel);
    case (sel)
      2'h0: blank_load = CNT_W'(BLANK0 - 1);
      2'h1: blank_load = CNT_W'(BLANK1 - 1);
      2'h2: blank_load = CNT_W'(BLANK2 - 1);
      default: blank_load = CNT_W'(BLANK3 - 1);
    endcase
  endfunction : blank_load

  // retry off-time for a select code, minus one
  function automatic logic [CNT_W-1:0] retry_load(input logic [1:0] sel);
    case (sel)
      2'h0: retry_load = CNT_W'(RETRY0 - 1);
      2'h1: retry_load = CNT_W'(RETRY1 - 1);
      2'h2: retry_load = CNT_W'(RETRY2 - 1);
      default: retry_load = CNT_W'(RETRY3 - 1);
    endcase
  endfunction : retry_load

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three flops, level taken once stages two and three agree

  localparam int NPIN = 6;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_r;
  logic [NPIN-1:0] s2_r;
  logic [NPIN-1:0] s3_r;
  logic [NPIN-1:0] lvl_r;
  logic aux_s;
  logic line_s;
  logic txen_s;
  logic txd_s;
  logic [1:0] oc_s;

  assign pin_raw = {drv_overcurrent_i, tx_data_pin_b_i, tx_enable_pin_b_i, line_b_i,
                    aux_input_b_i};

  // s1 feeds only s2, so metastability never reaches any decision logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a bit whose stages disagree keeps its old level for one more cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_r <= '0;
    end else begin
      lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
    end
  end

  assign aux_s = lvl_r[0];
  assign line_s = lvl_r[1];
  assign txen_s = lvl_r[2];
  assign txd_s = lvl_r[3];
  assign oc_s = lvl_r[5:4];

  ////////////////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after request, write lands on the ack edge

  cbl_wb_req_t req;
  logic req_act;
  logic ack_r;
  logic [31:0] dat_r;
  logic [5:0] idx;
  logic wr_go;
  logic wr_cfg_b;
  logic wr_limit;
  logic wr_pctl;
  logic wr_istat;
  logic wr_imask;

  assign req = '{adr: adr_i, dat: dat_i, sel: sel_i, we: we_i};
  assign req_act = cyc_i & stb_i;
  assign idx = req.adr[IDX_LSB +: 6];
  assign wr_go = req_act & ack_r & req.we & req.sel[0];
  assign wr_cfg_b = wr_go & (idx == IDX_CHAN_B_CFG);
  assign wr_limit = wr_go & (idx == IDX_DRV_LIMIT);
  assign wr_pctl = wr_go & (idx == IDX_PIN_CTRL);
  assign wr_istat = wr_go & (idx == IDX_IRQ_STAT);
  assign wr_imask = wr_go & (idx == IDX_IRQ_MASK);

  // ack pulses one cycle per request; unmapped addresses still answer, reading zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req_act & ~ack_r;
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;

  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [B_WR_MSB:0] cfg_b_r;
  cbl_limit_t limit_r;
  logic soft_pin_r;

  // reads never touch these, only writes with byte lane 0 do
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_b_r <= CFG_B_RST;
      limit_r <= LIMIT_RST;
      soft_pin_r <= 1'b0;
    end else begin
      if (wr_cfg_b) begin
        cfg_b_r <= req.dat[B_WR_MSB:0];
      end
      if (wr_limit) begin
        limit_r <= req.dat[7:0];
      end
      if (wr_pctl) begin
        soft_pin_r <= req.dat[PC_SOFT];
      end
    end
  end

  // front-end controls straight from register bits
  assign aux_in_b_filter_on_o = cfg_b_r[B_FILT];
  assign aux_in_b_threshold_type_o = cfg_b_r[B_THRESH];
  assign aux_in_b_source_on_o = cfg_b_r[B_SRC];
  assign aux_in_b_sink_on_o = cfg_b_r[B_SINK];
  assign driver_limit_sel_o = limit_r.limit_sel;
  assign driver_limit_off_o = limit_r.limit_off;

  // soft pin control swaps the tx pins for the register bits
  assign line_b_tx_en_o = soft_pin_r ? cfg_b_r[B_TX_EN] : txen_s;
  assign line_b_tx_data_o = soft_pin_r ? cfg_b_r[B_TX_DAT] : txd_s;

  ////////////////////////////////////////////////////////////////////////////////
  // aux input B glitch filter: level accepted after FILT stable cycles

  logic [FCNT_W-1:0] fcnt_r;
  logic aux_filt_r;
  logic aux_flag;

  // shorter pulses restart the count and never reach the flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fcnt_r <= '0;
      aux_filt_r <= 1'b0;
    end else if (aux_s == aux_filt_r) begin
      fcnt_r <= '0;
    end else if (fcnt_r == FCNT_W'(FILT - 1)) begin
      fcnt_r <= '0;
      aux_filt_r <= aux_s;
    end else begin
      fcnt_r <= fcnt_r + 1'b1;
    end
  end

  assign aux_flag = cfg_b_r[B_FILT] ? aux_filt_r : aux_s;

  ////////////////////////////////////////////////////////////////////////////////
  // driver fault sequencers, one per line driver

  cbl_flt_st_t st_r [2];
  logic [CNT_W-1:0] cnt_r [2];
  logic [1:0] drv_en;
  logic [1:0] flt_evt;

  // line A has no enable in this bank, so only a reconfigure frees it
  assign drv_en = {line_b_tx_en_o, 1'b1};

  for (genvar gi = 0; gi < 2; gi++) begin : g_seq
    // one process owns state, counter and the fault event of a driver
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        st_r[gi] <= ST_NORMAL;
        cnt_r[gi] <= '0;
        flt_evt[gi] <= 1'b0;
      end else begin
        flt_evt[gi] <= 1'b0;
        case (st_r[gi])
          ST_NORMAL: begin
            if (oc_s[gi] & drv_en[gi]) begin
              st_r[gi] <= ST_BLANK;
              cnt_r[gi] <= blank_load(limit_r.blank_sel);
            end
          end
          ST_BLANK: begin
            if (!oc_s[gi]) begin
              st_r[gi] <= ST_NORMAL;
            end else if (cnt_r[gi] == '0) begin
              flt_evt[gi] <= 1'b1;
              if (limit_r.retry_on) begin
                st_r[gi] <= ST_OFF;
                cnt_r[gi] <= retry_load(limit_r.retry_sel);
              end else begin
                st_r[gi] <= ST_LATCH;
              end
            end else begin
              cnt_r[gi] <= cnt_r[gi] - 1'b1;
            end
          end
          ST_OFF: begin
            if (cnt_r[gi] == '0) begin
              st_r[gi] <= ST_RECHECK;
              cnt_r[gi] <= blank_load(limit_r.blank_sel);
            end else begin
              cnt_r[gi] <= cnt_r[gi] - 1'b1;
            end
          end
          ST_RECHECK: begin
            if (cnt_r[gi] != '0) begin
              cnt_r[gi] <= cnt_r[gi] - 1'b1;
            end else if (oc_s[gi]) begin
              st_r[gi] <= ST_OFF;
              cnt_r[gi] <= retry_load(limit_r.retry_sel);
            end else begin
              st_r[gi] <= ST_NORMAL;
            end
          end
          ST_LATCH: begin
            if (wr_limit || !drv_en[gi]) begin
              st_r[gi] <= ST_NORMAL;
            end
          end
          default: begin
            st_r[gi] <= ST_NORMAL;
          end
        endcase
      end
    end

    // driver is held off during the retry off-time and while latched off
    assign drv_allow_o[gi] = (st_r[gi] != ST_OFF) && (st_r[gi] != ST_LATCH);
    assign drv_fault_o[gi] = (st_r[gi] == ST_OFF) || (st_r[gi] == ST_RECHECK) ||
                             (st_r[gi] == ST_LATCH);

    // a fault that persists through recheck goes back to off with the flag held
    sequence s_recheck_end;
      (st_r[gi] == ST_RECHECK) && (cnt_r[gi] == '0) && oc_s[gi];
    endsequence
    sequence s_off_flagged;
      (st_r[gi] == ST_OFF) && drv_fault_o[gi] && !drv_allow_o[gi];
    endsequence
    AST_RECHECK_REOFF: assert property (@(posedge clk_i) disable iff (rst_i)
      s_recheck_end |=> s_off_flagged)
      else $error("persisting fault did not switch the driver off again");

    AST_FAULT_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_r[gi] == ST_RECHECK) && (cnt_r[gi] == '0) && !oc_s[gi]
      |=> !drv_fault_o[gi] && drv_allow_o[gi])
      else $error("cleared fault did not restore the driver");

    AST_FAULT_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(drv_fault_o[gi]) |-> flt_evt[gi] && !drv_allow_o[gi] &&
      $past(st_r[gi] == ST_BLANK))
      else $error("fault flag rose without a completed blanking time");

    AST_OFF_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(st_r[gi] == ST_OFF) && $past(st_r[gi] == ST_BLANK)
      |-> cnt_r[gi] == retry_load($past(limit_r.retry_sel)))
      else $error("retry timer loaded with the wrong off-time");

    AST_LATCH_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_r[gi] == ST_LATCH) && !wr_limit && drv_en[gi] |=> st_r[gi] == ST_LATCH)
      else $error("latched-off driver released without a cause");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky fault events, write one to clear, set beats clear

  logic [1:0] irq_st_r;
  logic [1:0] irq_mask_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_r <= IRQ_RST;
      irq_mask_r <= IRQ_RST;
    end else begin
      irq_st_r <= flt_evt | (irq_st_r & ~(wr_istat ? req.dat[1:0] : 2'h0));
      if (wr_imask) begin
        irq_mask_r <= req.dat[1:0];
      end
    end
  end

  assign irq_o = |(irq_st_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////////
  // read data, captured as ack rises; unmapped reads give zero

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= '0;
    end else if (req_act & ~ack_r) begin
      case (idx)
        IDX_CHAN_B_CFG: dat_r <= {24'h000000, aux_flag, line_s, cfg_b_r};
        IDX_DRV_LIMIT: dat_r <= {24'h000000, limit_r};
        IDX_PIN_CTRL: dat_r <= {31'h00000000, soft_pin_r};
        IDX_FAULT_STAT: dat_r <= {30'h00000000, drv_fault_o};
        IDX_IRQ_STAT: dat_r <= {30'h00000000, irq_st_r};
        IDX_IRQ_MASK: dat_r <= {30'h00000000, irq_mask_r};
        default: dat_r <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks on the register side

  AST_TXEN_SOFT: assert property (@(posedge clk_i) disable iff (rst_i)
    soft_pin_r |-> line_b_tx_en_o == cfg_b_r[B_TX_EN])
    else $error("tx enable not taken from register under soft control");

  AST_TX_PINS: assert property (@(posedge clk_i) disable iff (rst_i)
    !soft_pin_r |-> line_b_tx_en_o == txen_s && line_b_tx_data_o == txd_s)
    else $error("tx pins not followed under pin control");

  AST_TXD_SOFT: assert property (@(posedge clk_i) disable iff (rst_i)
    soft_pin_r && $stable(cfg_b_r) |-> line_b_tx_data_o == cfg_b_r[B_TX_DAT])
    else $error("tx data not taken from register under soft control");

  AST_FILTER_STABLE: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_b_r[B_FILT] && $changed(aux_filt_r) |-> $past(aux_s) == aux_filt_r &&
    $past(aux_s, 2) == aux_filt_r)
    else $error("filtered aux level changed on a short pulse");

  AST_CFG_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_cfg_b |=> aux_in_b_source_on_o == $past(req.dat[B_SRC]) &&
    aux_in_b_sink_on_o == $past(req.dat[B_SINK]) &&
    aux_in_b_threshold_type_o == $past(req.dat[B_THRESH]))
    else $error("channel B config write did not reach the front end");

  AST_LIMIT_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_limit |=> driver_limit_sel_o == $past(req.dat[7:6]) &&
    driver_limit_off_o == $past(req.dat[5]))
    else $error("limit write did not reach the driver controls");

  AST_READ_NO_EFFECT: assert property (@(posedge clk_i) disable iff (rst_i)
    req_act && !req.we |=> $stable(cfg_b_r) && $stable(limit_r) && $stable(irq_mask_r))
    else $error("a read changed a register");

  sequence s_req_taken;
    req_act && !ack_r;
  endsequence
  AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    s_req_taken |=> ack_r ##1 !ack_r)
    else $error("ack not a single pulse one cycle after the request");

  AST_AUX_READ: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_req_taken and (idx == IDX_CHAN_B_CFG && !cfg_b_r[B_FILT]))
    |=> dat_r[B_AUX_LVL] == $past(aux_s) && dat_r[B_LINE_LVL] == $past(line_s))
    else $error("level flags do not show the synchronised pins");

endmodule : cbl_io_limit
`default_nettype wire

//--- testbench/cbl_field_model.sv
// Purpose: field-side model of the line loads and shorts seen by the two drivers
// Assumes: a short only draws overcurrent while its driver is allowed and driving
// Notes: line B idles low through the load's pull-down when released
`timescale 1ns/1ps
`default_nettype none
module cbl_field_model (
  input wire logic [1:0] short_i,
  input wire logic [1:0] drv_allow_i,
  input wire logic tx_en_i,
  input wire logic tx_data_i,
  output logic line_b_o,
  output logic [1:0] overcurrent_o
);
  // a released line falls to the pull-down level, never holds the last bit
  assign line_b_o = tx_en_i & drv_allow_i[1] & tx_data_i;
  // line A counts as always enabled, line B only while transmitting
  assign overcurrent_o = short_i & drv_allow_i & {tx_en_i, 1'b1};
endmodule : cbl_field_model
`default_nettype wire

//--- testbench/test_cbl_io_limit.sv
// Purpose: self-checking bench for the channel B config bank and driver fault sequencer
// Assumes: short blank/retry/filter parameters; all times checked in those cycles
// Notes: random config values come from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module test_cbl_io_limit;
  import cbl_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, aux = 0, pin_en = 0, pin_dat = 0;
  logic [7:0] adr = 0, d, q;
  logic [3:0] sel = 4'h1, fe;
  logic [31:0] dat = 0, dat_o;
  logic ack_o, tx_en_o, tx_dat_o, lim_off, irq, line_b;
  logic [1:0] short = 0, x, lim_sel, allow, fault, oc;
  int i, n, seed, cycles = 0, tests_run = 0, n_mismatch = 0;
  // short timing so every code runs in a few hundred cycles
  localparam int BL0 = 8, BL1 = 16, BL2 = 32, BL3 = 48, FLT = 4;
  localparam int RT0 = 40, RT1 = 60, RT2 = 80, RT3 = 100;
  int bl[4] = '{BL0, BL1, BL2, BL3};
  int rt[4] = '{RT0, RT1, RT2, RT3};
  logic [7:0] ra[3] = '{8'h6c, 8'h70, 8'hfc};

  cbl_io_limit #(.BLANK0(BL0), .BLANK1(BL1), .BLANK2(BL2), .BLANK3(BL3), .RETRY0(RT0),
    .RETRY1(RT1), .RETRY2(RT2), .RETRY3(RT3), .FILT(FLT)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .aux_input_b_i(aux),
    .line_b_i(line_b), .tx_enable_pin_b_i(pin_en), .tx_data_pin_b_i(pin_dat),
    .drv_overcurrent_i(oc), .line_b_tx_en_o(tx_en_o), .line_b_tx_data_o(tx_dat_o),
    .aux_in_b_filter_on_o(fe[3]), .aux_in_b_threshold_type_o(fe[2]),
    .aux_in_b_source_on_o(fe[1]), .aux_in_b_sink_on_o(fe[0]),
    .driver_limit_sel_o(lim_sel), .driver_limit_off_o(lim_off), .drv_allow_o(allow),
    .drv_fault_o(fault), .irq_o(irq));

  cbl_field_model field (.short_i(short), .drv_allow_i(allow), .tx_en_i(tx_en_o),
    .tx_data_i(tx_dat_o), .line_b_o(line_b), .overcurrent_o(oc));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard; the whole run needs under two thousand cycles
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one classic cycle; held until ack is sampled, then released
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= {24'h0, v};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc <= 0;
    stb <= 0;
  endtask : wb

  // s 0..1 watches a fault flag, 2..3 an allow flag
  task automatic wait_bit(input int s, input logic v, output int k);
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while ((s < 2 ? fault[s] : allow[s-2]) !== v && k < 2000);
  endtask : wait_bit

  function automatic logic [7:0] exp_cfg(input logic a, input logic l, input logic [7:0] w);
    return {a, l, w[5:0]};
  endfunction : exp_cfg

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 55204;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    chk("allow", allow, 2'b11);
    wb(1, 8'hfc, 8'hff);
    foreach (ra[j]) begin
      wb(0, ra[j], 0);
      chk("reset read", q, 0);
    end
    // random config and limit values, every limit code once or more
    for (i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      aux <= d[7];
      wb(1, 8'h6c, d);
      repeat (12) @(posedge clk_i);
      wb(0, 8'h6c, 0);
      chk("cfg", q, exp_cfg(d[7], 1'b0, d));
      chk("front end", fe, d[3:0]);
      d = 8'($random(seed));
      d[7:6] = i[1:0];
      wb(1, 8'h70, d);
      wb(0, 8'h70, 0);
      chk("limit", q, d);
      chk("limit out", {lim_sel, lim_off}, d[7:5]);
    end
    // a two-cycle pulse must not pass the filter, a steady level must
    wb(1, 8'h6c, 8'h08);
    aux <= 0;
    repeat (12) @(posedge clk_i);
    aux <= 1;
    repeat (2) @(posedge clk_i);
    aux <= 0;
    repeat (12) @(posedge clk_i);
    wb(0, 8'h6c, 0);
    chk("glitch", q[7], 0);
    aux <= 1;
    repeat (12) @(posedge clk_i);
    wb(0, 8'h6c, 0);
    chk("steady", q[7], 1);
    // pins against register bits, both ways of soft control
    for (i = 0; i < 8; i++) begin
      wb(1, 8'h80, {7'h0, i[2]});
      wb(1, 8'h6c, {2'b0, ~i[1:0], 4'h0});
      pin_en <= i[1];
      pin_dat <= i[0];
      repeat (8) @(posedge clk_i);
      x = i[2] ? ~i[1:0] : i[1:0];
      chk("tx", {tx_en_o, tx_dat_o}, x);
      wb(0, 8'h6c, 0);
      chk("line level", q[6], x[1] & x[0]);
    end
    // shorted line A under autoretry, each blank and retry code
    for (i = 0; i < 4; i++) begin
      wb(1, 8'h70, {3'b0, i[1:0], i[1:0], 1'b1});
      short <= 2'b01;
      wait_bit(0, 1, n);
      chk("blank", n >= bl[i] && n <= bl[i] + 7, 1);
      wait_bit(2, 1, n);
      chk("off", n >= rt[i] && n <= rt[i] + 3, 1);
      wait_bit(2, 0, n);
      chk("recheck", {fault[0], n >= bl[i] && n <= bl[i] + 4}, 2'b11);
      short <= 2'b00;
      wait_bit(0, 0, n);
      chk("clear", {fault[0], allow[0]}, 2'b01);
    end
    // fault event raises status; mask gates the line; write one clears
    wb(0, 8'h88, 0);
    chk("irq status", q, 8'h01);
    chk("irq masked", irq, 0);
    wb(1, 8'h8c, 8'h01);
    repeat (2) @(posedge clk_i);
    chk("irq on", irq, 1);
    wb(1, 8'h88, 8'h01);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", irq, 0);
    // no autoretry, as a heavy load would want: line B stays off until rewritten
    wb(1, 8'h6c, 8'h20);
    wb(1, 8'h70, 8'h00);
    short <= 2'b10;
    wait_bit(1, 1, n);
    repeat (150) @(posedge clk_i);
    short <= 2'b00;
    repeat (10) @(posedge clk_i);
    chk("latched", {fault[1], allow[1]}, 2'b10);
    wb(1, 8'h70, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("unlatched", {fault[1], allow[1]}, 2'b01);
    // byte lane 0 off: the write must not land
    sel <= 4'h0;
    wb(1, 8'h70, 8'hff);
    sel <= 4'h1;
    wb(0, 8'h70, 0);
    chk("lane off", q, 0);
    // reset in mid-run with both registers set: they come back as zero
    wb(1, 8'h6c, 8'h3f);
    wb(1, 8'h70, 8'hff);
    rst_i <= 1;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 8'h6c, 0);
    chk("mid reset cfg", q[5:0], 0);
    wb(0, 8'h70, 0);
    chk("mid reset limit", q, 0);
    report_and_stop();
  end
endmodule : test_cbl_io_limit
`default_nettype wire
